// File: common/rtc_timer_pkg.sv
// constants, types and register map of the periodic countdown timer
// assumes a 25 MHz apb clock and 8-bit registers in the low data lanes
package rtc_timer_pkg;

	// apb address width, byte addressed
	localparam int ADDR_W = 8;

	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_PRESET_LO = 4'hB;
	localparam logic [3:0] IDX_PRESET_HI = 4'hC;
	localparam logic [3:0] IDX_EXT_CTRL = 4'hD;
	localparam logic [3:0] IDX_FLAGS = 4'hE;
	localparam logic [3:0] IDX_IRQ_CTRL = 4'hF;
	// index bit that selects the alias bank 0x10 higher
	localparam int IDX_ALIAS_BIT = 4;

	// field positions
	localparam int EXT_RUN_BIT = 4;
	localparam int EXT_SRC_LSB = 0;
	localparam int FLG_TIMER_BIT = 4;
	localparam int CTL_UIE_BIT = 5;
	localparam int CTL_TIE_BIT = 4;
	localparam int CTL_AIE_BIT = 3;
	localparam int CTL_STOP_BIT = 0;

	// writable bits of the interrupt control register; bit 1 is fixed zero
	localparam logic [7:0] CTL_WR_MASK = 8'hFD;
	// reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;
	// preset low nibble of the high register holds weights 256 to 2048
	localparam int PRESET_HI_BITS = 4;

	// countdown source choices
	typedef enum logic [1:0] {
		SRC_4096HZ = 2'h0,
		SRC_64HZ = 2'h1,
		SRC_SECOND = 2'h2,
		SRC_MINUTE = 2'h3
	} src_sel_type;

	// timing, figures in ns
	localparam int CLK_PERIOD_NS = 40;
	localparam int FAST_TICK_NS = 244140;
	localparam int REL_FAST_NS = 122000;
	localparam int REL_SLOW_NS = 7812500;
	localparam int FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
	localparam int REL_FAST_CYC = REL_FAST_NS / CLK_PERIOD_NS;
	localparam int REL_SLOW_CYC = REL_SLOW_NS / CLK_PERIOD_NS;
	// fast ticks per slower source, seconds per minute
	localparam int DIV_64HZ = 64;
	localparam int DIV_SECOND = 4096;
	localparam int DIV_MINUTE = 60;

	// timer configuration as seen by the countdown logic
	typedef struct packed {
		logic run;
		logic timer_irq_en;
		logic stop;
		src_sel_type src;
		logic [11:0] preset;
	} timer_cfg_type;

endpackage : rtc_timer_pkg

// File: design/tick_divider.sv
// enable-pulse divider: one tick every DIV input steps
// assumes step_in and clear come from logic on pclk
module tick_divider #(
	parameter int DIV = 64
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic clear,
	input wire logic step_in,
	// output pulse
	output logic tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	// refuse a divide ratio the counter cannot serve
	generate
		if (DIV < 1) begin : g_bad_div
			$error("tick_divider: DIV must be at least 1");
		end
	endgenerate

	logic [CW-1:0] cnt_q, cnt_d; // steps seen so far
	logic tick_q, tick_d; // registered pulse

	// next count and pulse
	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (clear) begin
			cnt_d = '0;
		end else if (step_in) begin
			if (cnt_q == CW'(DIV - 1)) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// register only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : tick_divider

// File: design/rtc_periodic_timer.sv
// periodic countdown timer with apb registers and open-drain irq pin
// assumes an apb master on pclk and same-clock update/alarm requests
module rtc_periodic_timer
	import rtc_timer_pkg::*;
#(
	parameter int FAST_TICK_CYCLES = rtc_timer_pkg::FAST_TICK_CYC,
	parameter int REL_SLOW_CYCLES = rtc_timer_pkg::REL_SLOW_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rtc_timer_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// requests from the update and alarm functions
	input wire logic update_irq_req,
	input wire logic alarm_irq_req,
	// open-drain interrupt pin
	output logic irq_out,
	output logic irq_oe_n
);

	localparam int REL_W = $clog2(REL_SLOW_CYCLES + 1);

	// refuse counts the logic cannot serve
	generate
		if (FAST_TICK_CYCLES < 1 || REL_SLOW_CYCLES < REL_FAST_CYC)
		begin : g_bad_param
			$error("rtc_periodic_timer: timing parameters out of range");
		end
	endgenerate

	// one-hot states of the timer part of the pin
	typedef enum logic [1:0] {
		IRQ_IDLE = 2'b01,
		IRQ_LOW = 2'b10
	} irq_state_type;

	// bus decode
	logic setup_ph; // first cycle of a transfer
	logic access_ph; // completing cycle of a transfer
	logic addr_hit; // address maps to a register
	logic [3:0] reg_idx; // register index, alias bit dropped
	logic wr_en; // write takes effect this edge
	logic [7:0] wbyte; // write data low lane

	// apb answer flops
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;

	// software registers
	logic [7:0] preset_lo_q, preset_lo_d;
	logic [7:0] preset_hi_q, preset_hi_d;
	logic [7:0] ext_q, ext_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic tflag_q, tflag_d; // sticky timer event flag

	// countdown
	timer_cfg_type cfg; // decoded configuration
	logic [11:0] count_q, count_d;
	logic run_rise; // run bit written from 0 to 1
	logic tie_off; // irq enable written from 1 to 0
	logic step; // one countdown step this cycle
	logic tmr_event; // count stepped from one, preset reloaded

	// source ticks
	logic fast_tick, tick_64, tick_sec, tick_min;
	logic slow_clear; // stop bit holds the slow dividers

	// pin machine
	irq_state_type irq_state_q, irq_state_d;
	logic [REL_W-1:0] rel_cnt_q, rel_cnt_d; // cycles left low
	logic [REL_W-1:0] rel_len; // release time for current source
	logic irq_oe_n_q, irq_oe_n_d;
	logic irq_out_q;

	// ---------------------------------------------------------------
	// apb decode; alias bank ignored so both addresses behave alike
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable && pready_q;
	assign reg_idx = paddr[5:2];
	assign addr_hit = (paddr[1:0] == 2'h0) && !paddr[7]
		&& (reg_idx >= IDX_PRESET_LO);
	assign wr_en = access_ph && pwrite && addr_hit;
	assign wbyte = pwdata[7:0];

	// read data and answer prepared in setup, shown in access
	// zero wait states, yet every bus output comes from a flop
	always_comb begin
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (setup_ph) begin
			pready_d = 1'b1;
			pslverr_d = !addr_hit;
			prdata_d = 32'h0000_0000;
			if (addr_hit && !pwrite) begin
				case (reg_idx)
					IDX_PRESET_LO: prdata_d[7:0] = preset_lo_q;
					IDX_PRESET_HI: prdata_d[7:0] = preset_hi_q;
					IDX_EXT_CTRL: prdata_d[7:0] = ext_q;
					// only the timer flag lives here; rest reads zero
					IDX_FLAGS: prdata_d[FLG_TIMER_BIT] = tflag_q;
					IDX_IRQ_CTRL: prdata_d[7:0] = ctrl_q;
					default: prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// apb answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ---------------------------------------------------------------
	// register writes; presets are plain storage whatever the run bit
	always_comb begin
		preset_lo_d = preset_lo_q;
		preset_hi_d = preset_hi_q;
		ext_d = ext_q;
		ctrl_d = ctrl_q;
		tflag_d = tflag_q;
		run_rise = 1'b0;
		tie_off = 1'b0;
		if (wr_en) begin
			case (reg_idx)
				IDX_PRESET_LO: preset_lo_d = wbyte;
				// upper nibble kept as free storage
				IDX_PRESET_HI: preset_hi_d = wbyte;
				IDX_EXT_CTRL: begin
					ext_d = wbyte;
					run_rise = wbyte[EXT_RUN_BIT] && !ext_q[EXT_RUN_BIT];
				end
				// write zero clears, write one does nothing
				IDX_FLAGS: begin
					if (!wbyte[FLG_TIMER_BIT]) begin
						tflag_d = 1'b0;
					end
				end
				IDX_IRQ_CTRL: begin
					ctrl_d = wbyte & CTL_WR_MASK;
					tie_off = ctrl_q[CTL_TIE_BIT] && !wbyte[CTL_TIE_BIT];
				end
				default: ;
			endcase
		end
		// a new event beats a clear in the same cycle
		if (tmr_event) begin
			tflag_d = 1'b1;
		end
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_lo_q <= REG_RESET;
			preset_hi_q <= REG_RESET;
			ext_q <= REG_RESET;
			ctrl_q <= REG_RESET;
			tflag_q <= 1'b0;
		end else begin
			preset_lo_q <= preset_lo_d;
			preset_hi_q <= preset_hi_d;
			ext_q <= ext_d;
			ctrl_q <= ctrl_d;
			tflag_q <= tflag_d;
		end
	end

	// decoded configuration
	assign cfg.run = ext_q[EXT_RUN_BIT];
	assign cfg.timer_irq_en = ctrl_q[CTL_TIE_BIT];
	assign cfg.stop = ctrl_q[CTL_STOP_BIT];
	assign cfg.src = src_sel_type'(ext_q[EXT_SRC_LSB +: 2]);
	assign cfg.preset = {preset_hi_q[PRESET_HI_BITS-1:0], preset_lo_q};

	// ---------------------------------------------------------------
	// source ticks; the second tick stands for the clock update instant
	assign slow_clear = cfg.stop;

	tick_divider #(.DIV(FAST_TICK_CYCLES)) u_div_fast (
		.pclk(pclk),
		.presetn(presetn),
		.clear(1'b0),
		.step_in(1'b1),
		.tick(fast_tick)
	);

	tick_divider #(.DIV(DIV_64HZ)) u_div_64 (
		.pclk(pclk),
		.presetn(presetn),
		.clear(slow_clear),
		.step_in(fast_tick),
		.tick(tick_64)
	);

	tick_divider #(.DIV(DIV_SECOND)) u_div_sec (
		.pclk(pclk),
		.presetn(presetn),
		.clear(slow_clear),
		.step_in(fast_tick),
		.tick(tick_sec)
	);

	tick_divider #(.DIV(DIV_MINUTE)) u_div_min (
		.pclk(pclk),
		.presetn(presetn),
		.clear(slow_clear),
		.step_in(tick_sec),
		.tick(tick_min)
	);

	// pick the countdown period; halted sources never step
	always_comb begin
		case (cfg.src)
			SRC_4096HZ: step = fast_tick;
			SRC_64HZ: step = tick_64 && !cfg.stop;
			// steps land on the update instant itself
			SRC_SECOND: step = tick_sec && !cfg.stop;
			SRC_MINUTE: step = tick_min && !cfg.stop;
			default: step = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// countdown; a preset written while running is taken only at reload
	always_comb begin
		count_d = count_q;
		tmr_event = 1'b0;
		if (run_rise) begin
			// never resume from a leftover count
			count_d = cfg.preset;
		end else if (cfg.run && step) begin
			if (count_q == 12'h001) begin
				tmr_event = 1'b1;
				count_d = cfg.preset;
			end else if (count_q == 12'h000) begin
				// zero preset gives no event, just retry the load
				count_d = cfg.preset;
			end else begin
				count_d = count_q - 12'h001;
			end
		end
	end

	// countdown flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 12'h000;
		end else begin
			count_q <= count_d;
		end
	end

	// ---------------------------------------------------------------
	// release time follows the source in force at the event
	assign rel_len = (cfg.src == SRC_4096HZ) ? REL_W'(REL_FAST_CYC)
		: REL_W'(REL_SLOW_CYCLES);

	// pin machine; stopping the timer lets a low pin run out
	always_comb begin
		irq_state_d = irq_state_q;
		rel_cnt_d = rel_cnt_q;
		case (irq_state_q)
			IRQ_IDLE: begin
				if (tmr_event && cfg.timer_irq_en && !tie_off) begin
					irq_state_d = IRQ_LOW;
					rel_cnt_d = rel_len;
				end
			end
			IRQ_LOW: begin
				if (tie_off) begin
					irq_state_d = IRQ_IDLE;
					rel_cnt_d = '0;
				end else if (tmr_event && cfg.timer_irq_en) begin
					rel_cnt_d = rel_len; // each event restarts the time
				end else if (rel_cnt_q <= REL_W'(1)) begin
					irq_state_d = IRQ_IDLE;
					rel_cnt_d = '0;
				end else begin
					// flag clears do not reach here
					rel_cnt_d = rel_cnt_q - REL_W'(1);
				end
			end
			default: begin
				irq_state_d = IRQ_IDLE;
				rel_cnt_d = '0;
			end
		endcase
	end

	// shared pin: any enabled source pulls it low
	always_comb begin
		irq_oe_n_d = !((irq_state_d == IRQ_LOW)
			|| (update_irq_req && ctrl_q[CTL_UIE_BIT])
			|| (alarm_irq_req && ctrl_q[CTL_AIE_BIT]));
	end

	// pin machine and pin flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_state_q <= IRQ_IDLE;
			rel_cnt_q <= '0;
			irq_oe_n_q <= 1'b1;
			irq_out_q <= 1'b0;
		end else begin
			irq_state_q <= irq_state_d;
			rel_cnt_q <= rel_cnt_d;
			irq_oe_n_q <= irq_oe_n_d;
			irq_out_q <= 1'b0;
		end
	end

	// open drain: level is always low, enable low means pulling
	assign irq_out = irq_out_q;
	assign irq_oe_n = irq_oe_n_q;

	// ---------------------------------------------------------------
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_from_preset: assert property (
		run_rise |=> count_q == $past(cfg.preset))
		else $error("run start did not load preset");

	a_event_at_one: assert property (
		tmr_event |-> count_q == 12'h001 && cfg.run && step)
		else $error("event without step from one");

	a_reload_after: assert property (
		(tmr_event && !run_rise) |=> count_q == $past(cfg.preset))
		else $error("preset not reloaded after event");

	a_flag_sticks: assert property (
		tmr_event |=> tflag_q ##1 (tflag_q || $past(wr_en)))
		else $error("timer flag lost");

	a_pin_needs_en: assert property (
		(irq_state_q == IRQ_IDLE && tmr_event && !cfg.timer_irq_en)
		|=> irq_state_q == IRQ_IDLE)
		else $error("pin pulled with enable off");

	a_release_load: assert property (
		(tmr_event && cfg.timer_irq_en && !tie_off) |=> rel_cnt_q == $past(rel_len)
		##1 (irq_oe_n_q == 1'b0 || $past(tie_off)))
		else $error("release time not loaded");

	a_release_end: assert property (
		(irq_state_q == IRQ_LOW && rel_cnt_q == REL_W'(1) && !tmr_event)
		|=> irq_state_q == IRQ_IDLE)
		else $error("pin not released at end of time");

	a_flag_clear_keep: assert property (
		(irq_state_q == IRQ_LOW && rel_cnt_q > REL_W'(1) && !tie_off
		&& wr_en && reg_idx == IDX_FLAGS) |=> irq_state_q == IRQ_LOW)
		else $error("flag clear changed pin");

	a_tie_release: assert property (
		tie_off |=> irq_state_q == IRQ_IDLE)
		else $error("enable off did not release pin");

	a_stop_halts: assert property (
		(cfg.stop && cfg.src != SRC_4096HZ && !run_rise)
		|=> $stable(count_q))
		else $error("halted source still counting");

	c_event_irq: cover property (tmr_event && cfg.timer_irq_en);
	c_auto_release: cover property (
		irq_state_q == IRQ_LOW ##1 irq_state_q == IRQ_IDLE);
	c_tie_off: cover property (tie_off && irq_state_q == IRQ_LOW);

endmodule : rtc_periodic_timer

// File: tb/host_model.sv
// host processor model: apb master plus the interrupt line it watches
// assumes an apb slave on pclk that answers within sixteen cycles
module host_model
	import rtc_timer_pkg::*;
(
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [rtc_timer_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// open-drain pin and the line as the board sees it
	input wire logic irq_out,
	input wire logic irq_oe_n,
	output logic irq_line_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// board pull-up holds a released line high
	assign irq_line_n = irq_oe_n ? 1'b1 : irq_out;

	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// one transfer; hung reports a slave that never answered
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output logic err,
		output logic hung);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// bounded wait for the answer
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge pclk);
		end
		hung = (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep their old value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
		// one idle edge so no signal is driven twice in a step
		@(posedge pclk);
	endtask : xfer

endmodule : host_model

// File: tb/periodic_countdown_timer_irq_tb.sv
// self-checking bench of the periodic countdown timer
// assumes the host model drives apb and resolves the interrupt line
module periodic_countdown_timer_irq_tb
	import rtc_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// fast tick shortened to four cycles
	localparam int FT = 4;
	logic pclk; // 25 MHz bus clock
	logic presetn; // async reset, active low
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic update_irq_req; // update function request
	logic alarm_irq_req; // alarm function request
	logic irq_out;
	logic irq_oe_n;
	logic irq_line_n; // resolved pin, 1 = released
	int failures;
	int cmp_count;

	// 40 ns clock
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	rtc_periodic_timer #(.FAST_TICK_CYCLES(FT), .REL_SLOW_CYCLES(3200))
		rtc_periodic_timer_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .update_irq_req(update_irq_req),
		.alarm_irq_req(alarm_irq_req), .irq_out(irq_out),
		.irq_oe_n(irq_oe_n));

	host_model host_model_inst (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
		.irq_line_n(irq_line_n));

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	// verdict and end of run
	task automatic finish_test();
		if (failures == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// register access by index; a hung bus ends the run
	task automatic bus(input logic w, input logic [5:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output logic err);
		logic hung;
		host_model_inst.xfer(w, {idx, 2'b00}, wd, rd, err, hung);
		if (hung) begin
			failures++;
			finish_test();
		end
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
		logic [7:0] rd;
		logic err;
		bus(1'b1, idx, wd, rd, err);
		check(err, 1'b0);
	endtask : wr

	task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] rd;
		logic err;
		bus(1'b0, idx, 8'h00, rd, err);
		check(err, 1'b0);
		check(rd, exp);
	endtask : rchk

	// bounded wait for the line to go low
	task automatic wait_low(output int n);
		n = 0;
		while (irq_line_n !== 1'b0) begin
			if (n == 9000) begin
				failures++;
				finish_test();
			end
			@(posedge pclk);
			n++;
		end
	endtask : wait_low

	// reset values, storage bits, fixed zeros, aliases, unmapped place
	task automatic t_regs();
		logic [7:0] rd;
		logic err;
		for (int i = 11; i < 16; i++) begin
			rchk(6'(i), REG_RESET);
		end
		wr(6'h1B, 8'hA5);
		rchk(6'h0B, 8'hA5);
		wr(6'h0C, 8'hF3);
		rchk(6'h1C, 8'hF3);
		wr(6'h0E, 8'hFF);
		rchk(6'h1E, 8'h00);
		wr(6'h1F, 8'hFF);
		rchk(6'h0F, 8'hFD);
		wr(6'h0F, 8'h00);
		// every source code is accepted and read back
		for (int s = 0; s < 4; s++) begin
			wr(6'h0D, 8'(s));
			rchk(6'h1D, 8'(s));
		end
		bus(1'b0, 6'h05, 8'h00, rd, err);
		check(err, 1'b1);
	endtask : t_regs

	// fast source: start from preset, reload, sticky flag
	task automatic t_count();
		wr(6'h0D, 8'h00);
		wr(6'h0B, 8'd100);
		wr(6'h0C, 8'h00);
		wr(6'h0F, 8'h01); // stop bit leaves the fast source running
		wr(6'h0D, 8'h10);
		cyc(300);
		rchk(6'h0E, 8'h00);
		cyc(120);
		rchk(6'h0E, 8'h10);
		wr(6'h0E, 8'h00);
		cyc(300);
		rchk(6'h0E, 8'h00);
		cyc(120);
		rchk(6'h0E, 8'h10);
		check(irq_line_n, 1'b1);
		// stop with a short count left, then restart
		cyc(300);
		wr(6'h0D, 8'h00);
		wr(6'h0E, 8'h00);
		wr(6'h0D, 8'h10);
		cyc(300);
		rchk(6'h0E, 8'h00);
		wr(6'h0D, 8'h00);
		wr(6'h0F, 8'h00);
	endtask : t_count

	// slow sources halt under the stop bit, tick from its release
	task automatic t_slow(input logic [7:0] src, input int per);
		wr(6'h0B, 8'h01);
		wr(6'h0F, 8'h01);
		wr(6'h0D, 8'h10 | src);
		cyc(per + 100);
		rchk(6'h0E, 8'h00);
		wr(6'h0F, 8'h00);
		cyc(per - per / 16);
		rchk(6'h0E, 8'h00);
		cyc(per / 8);
		rchk(6'h0E, 8'h10);
		wr(6'h0D, 8'h00);
		wr(6'h0E, 8'h00);
	endtask : t_slow

	// pin timing: weight 2048, auto release, flag clear, enable off, stop
	task automatic t_irq();
		int n;
		wr(6'h0B, 8'h00);
		wr(6'h0C, 8'h08);
		wr(6'h0F, 8'h10);
		wr(6'h0D, 8'h10);
		wait_low(n);
		check(n >= 2046 * FT && n <= 2048 * FT + 6, 1'b1);
		cyc(REL_FAST_CYC - 50);
		check(irq_line_n, 1'b0);
		cyc(60);
		check(irq_line_n, 1'b1);
		wait_low(n);
		rchk(6'h0E, 8'h10);
		wr(6'h0E, 8'h00);
		check(irq_line_n, 1'b0);
		wr(6'h0F, 8'h00);
		cyc(3);
		check(irq_line_n, 1'b1);
		wr(6'h0F, 8'h10);
		wait_low(n);
		wr(6'h0D, 8'h00);
		wr(6'h0E, 8'h00);
		cyc(REL_FAST_CYC + 10);
		check(irq_line_n, 1'b1);
		rchk(6'h0E, 8'h00);
		wr(6'h0F, 8'h00);
	endtask : t_irq

	// shared pin follows the other requests and their enables
	task automatic t_share(input logic [7:0] en);
		wr(6'h0F, en);
		update_irq_req <= 1'b1;
		alarm_irq_req <= 1'b1;
		cyc(3);
		check(irq_line_n, 1'b0);
		wr(6'h0F, 8'h00);
		cyc(3);
		check(irq_line_n, 1'b1);
		update_irq_req <= 1'b0;
		alarm_irq_req <= 1'b0;
		cyc(2);
	endtask : t_share

	// main sequence
	initial begin
		failures = 0;
		cmp_count = 0;
		presetn = 1'b0;
		update_irq_req = 1'b0;
		alarm_irq_req = 1'b0;
		cyc(16);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_count();
		t_slow(8'h01, DIV_64HZ * FT);
		t_slow(8'h02, DIV_SECOND * FT);
		t_irq();
		t_share(8'h08);
		t_share(8'h20);
		finish_test();
	end

endmodule : periodic_countdown_timer_irq_tb
